// File: hdl/pprc_top.v
// recovery, timer and emulation configuration registers with axi4-lite
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "pprc_defs.vh"
module pprc_top #(
  parameter CLK_PER_MS = `PPRC_CLK_KHZ,
  parameter TW = 11
) (
  input wire mclk,
  input wire rst_n,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire errorIn,
  input wire overTempIn,
  input wire backDriveIn,
  input wire tempHighIn,
  input wire busDischargedIn,
  input wire devicePresentIn,
  input wire power_switch_enable_input,
  input wire mode_select_a,
  input wire mode_select_b,
  input wire emulation_enable_input,
  input wire sleepIn,
  input wire [10:0] vbusMilliVolt,
  input wire [7:0] busCurrentSteps,
  output reg useTestCurrent,
  output reg portSwitchOn,
  output reg errorActive,
  output reg cooldownHold,
  output reg attachEvalEnable,
  output reg removalDetect,
  output reg attachDetect,
  output reg emulationSuccess,
  output reg dcpProfileEnable,
  output reg [6:0] legacyProfileEnable,
  output reg irq
);
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  localparam NP = 11;
  wire [NP-1:0] pinRaw;
  reg [NP-1:0] pinMeta;
  reg [NP-1:0] pinSync;
  reg tempHighLast;
  reg dischLast;
  assign pinRaw = {sleepIn, emulation_enable_input, mode_select_a,
    mode_select_b, power_switch_enable_input, devicePresentIn,
    busDischargedIn, tempHighIn, backDriveIn, overTempIn, errorIn};
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pinMeta <= {NP{1'b0}};
      pinSync <= {NP{1'b0}};
    end
    else
    begin
      pinMeta <= pinRaw;
      pinSync <= pinMeta;
    end
  end
  wire errS = pinSync[0];
  wire otS = pinSync[1];
  wire bdS = pinSync[2];
  wire thS = pinSync[3];
  wire dsS = pinSync[4];
  wire devS = pinSync[5];
  wire pweS = pinSync[6];
  wire [2:0] modeS = {pinSync[9], pinSync[8], pinSync[7]};
  wire sleepS = pinSync[10];
  // ----------------------------------------------------------------
  // millisecond tick
  // ----------------------------------------------------------------
  reg [15:0] divCnt;
  reg msTick;
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      divCnt <= 16'h0000;
      msTick <= 1'b0;
    end
    else if (divCnt == CLK_PER_MS[15:0] - 16'h0001)
    begin
      divCnt <= 16'h0000;
      msTick <= 1'b1;
    end
    else
    begin
      divCnt <= divCnt + 16'h0001;
      msTick <= 1'b0;
    end
  end
  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  reg [6:0] artReg;
  reg [3:0] thrReg;
  reg [4:0] timReg;
  reg [7:0] stdReg;
  reg [6:0] legReg;
  reg [3:0] intStatus;
  reg [3:0] intMask;
  reg [3:0] intEvent;
  wire [2:0] cycCode = artReg[`PPRC_CYC_HI:`PPRC_CYC_LO];
  wire [1:0] tstCode = artReg[`PPRC_TST_HI:`PPRC_TST_LO];
  wire [1:0] vtsCode = artReg[`PPRC_VTS_HI:`PPRC_VTS_LO];
  wire [1:0] coolCode = timReg[`PPRC_COOL_HI:`PPRC_COOL_LO];
  wire [2:0] capCode = timReg[`PPRC_CAP_HI:`PPRC_CAP_LO];
  // code 100 lands on 35 ms with the same step
  wire [TW-1:0] cycMs = `PPRC_CYC_BASE_MS
    + {8'h00, cycCode} * `PPRC_STEP5_MS;
  wire [TW-1:0] tstMs = `PPRC_TST_BASE_MS
    + {9'h000, tstCode} * `PPRC_STEP5_MS;
  wire [10:0] vtestMv = ({9'h000, vtsCode} + 11'd1)
    * `PPRC_VTS_STEP_MV;
  wire [TW-1:0] coolMs = `PPRC_COOL_BASE_MS << coolCode;
  wire [TW-1:0] capMs = (capCode == `PPRC_CAP_LONG_CODE) ?
    `PPRC_CAP_MAX_MS :
    ({8'h00, capCode} + 11'd1) * `PPRC_CAP_STEP_MS;
  // ----------------------------------------------------------------
  // timers
  // ----------------------------------------------------------------
  reg cycStart;
  reg tstStart;
  reg coolStart;
  reg capStart;
  wire cycRun;
  wire cycDone;
  wire tstRun;
  wire tstDone;
  wire coolRun;
  wire coolDone;
  wire capRun;
  wire capDone;
  pprc_ms_timer #(.W(TW)) cycTimer (.mclk(mclk), .rst_n(rst_n),
    .msTick(msTick), .start(cycStart), .loadMs(cycMs),
    .running(cycRun), .done(cycDone));
  pprc_ms_timer #(.W(TW)) tstTimer (.mclk(mclk), .rst_n(rst_n),
    .msTick(msTick), .start(tstStart), .loadMs(tstMs),
    .running(tstRun), .done(tstDone));
  pprc_ms_timer #(.W(TW)) coolTimer (.mclk(mclk), .rst_n(rst_n),
    .msTick(msTick), .start(coolStart), .loadMs(coolMs),
    .running(coolRun), .done(coolDone));
  pprc_ms_timer #(.W(TW)) capTimer (.mclk(mclk), .rst_n(rst_n),
    .msTick(msTick), .start(capStart), .loadMs(capMs),
    .running(capRun), .done(capDone));
  // ----------------------------------------------------------------
  // auto-recovery state machine
  // ----------------------------------------------------------------
  localparam S_IDLE = 4'b0001;
  localparam S_CYCLE = 4'b0010;
  localparam S_CHECK = 4'b0100;
  localparam S_TEST = 4'b1000;
  reg [3:0] state;
  reg shortPulse;
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= S_IDLE;
      cycStart <= 1'b0;
      tstStart <= 1'b0;
      useTestCurrent <= 1'b0;
      portSwitchOn <= 1'b0;
      errorActive <= 1'b0;
      shortPulse <= 1'b0;
    end
    else
    begin
      cycStart <= 1'b0;
      tstStart <= 1'b0;
      shortPulse <= 1'b0;
      case (state)
        S_IDLE:
        begin
          if (errS)
          begin
            state <= S_CYCLE;
            cycStart <= 1'b1;
            errorActive <= 1'b1;
            portSwitchOn <= 1'b0;
          end
        end
        S_CYCLE:
        begin
          if (cycDone)
            state <= S_CHECK;
        end
        S_CHECK:
        begin
          if (!otS && !bdS)
          begin
            state <= S_TEST;
            useTestCurrent <= 1'b1;
            portSwitchOn <= 1'b1;
            tstStart <= 1'b1;
          end
          else
          begin
            state <= S_CYCLE;
            cycStart <= 1'b1;
          end
        end
        S_TEST:
        begin
          if (tstDone)
          begin
            useTestCurrent <= 1'b0;
            if (vbusMilliVolt < vtestMv)
            begin
              state <= S_CYCLE;
              cycStart <= 1'b1;
              portSwitchOn <= 1'b0;
              shortPulse <= 1'b1;
            end
            else
            begin
              state <= S_IDLE;
              errorActive <= 1'b0;
            end
          end
        end
        default:
          state <= S_IDLE;
      endcase
    end
  end
  // ----------------------------------------------------------------
  // cooldown, cap charge, attach and emulation outputs
  // ----------------------------------------------------------------
  wire capLong = capCode > `PPRC_CAP_800_CODE;
  wire next_success = busCurrentSteps > {4'h0, thrReg};
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tempHighLast <= 1'b0;
      dischLast <= 1'b0;
      coolStart <= 1'b0;
      capStart <= 1'b0;
      cooldownHold <= 1'b0;
      attachEvalEnable <= 1'b0;
      removalDetect <= 1'b0;
      attachDetect <= 1'b0;
      emulationSuccess <= 1'b0;
      dcpProfileEnable <= 1'b0;
      legacyProfileEnable <= 7'h00;
      intEvent <= 4'h0;
    end
    else
    begin
      tempHighLast <= thS;
      dischLast <= dsS;
      coolStart <= thS && !tempHighLast;
      capStart <= dsS && !dischLast;
      cooldownHold <= coolStart || (coolRun && !coolDone);
      attachEvalEnable <= !capStart && !capRun;
      removalDetect <= capDone && capLong && devS && !pweS;
      attachDetect <= removalDetect;
      emulationSuccess <= next_success;
      dcpProfileEnable <= (modeS == `PPRC_DCP_MODE) ||
        !stdReg[`PPRC_DCP_BIT];
      legacyProfileEnable <= ~legReg;
      intEvent <= {capDone, coolDone, next_success && !emulationSuccess,
        shortPulse};
    end
  end
  // ----------------------------------------------------------------
  // axi4-lite write channel
  // ----------------------------------------------------------------
  reg awHeld;
  reg wHeld;
  reg [7:0] awIdx;
  reg [7:0] wByte;
  reg wLane;
  wire doWrite = awHeld && wHeld && !s_axi_bvalid;
  wire wrHit = (awIdx == `PPRC_IDX_ART) || (awIdx == `PPRC_IDX_THR) ||
    (awIdx == `PPRC_IDX_TIM) || (awIdx == `PPRC_IDX_STD) ||
    (awIdx == `PPRC_IDX_LEG) || (awIdx == `PPRC_IDX_IST) ||
    (awIdx == `PPRC_IDX_IMK) || (awIdx == `PPRC_IDX_STA);
  wire wrEn = doWrite && wLane;
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awIdx <= 8'h00;
      wByte <= 8'h00;
      wLane <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PPRC_RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= !awHeld && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !wHeld && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        awHeld <= 1'b1;
        awIdx <= {2'b00, s_axi_awaddr[7:2]};
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wHeld <= 1'b1;
        wByte <= s_axi_wdata[7:0];
        wLane <= s_axi_wstrb[0];
      end
      if (doWrite)
      begin
        awHeld <= 1'b0;
        wHeld <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrHit ? `PPRC_RESP_OKAY : `PPRC_RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end
  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      artReg <= `PPRC_RST_ART;
      thrReg <= `PPRC_RST_THR;
      timReg <= `PPRC_RST_TIM;
      stdReg <= `PPRC_RST_STD;
      legReg <= `PPRC_RST_LEG;
      intMask <= 4'h0;
      intStatus <= 4'h0;
      irq <= 1'b0;
    end
    else
    begin
      // sleep leaves the other registers untouched
      if (sleepS)
        thrReg <= `PPRC_RST_THR;
      else if (wrEn && awIdx == `PPRC_IDX_THR)
        thrReg <= wByte[3:0];
      if (wrEn && awIdx == `PPRC_IDX_ART)
        artReg <= wByte[6:0];
      if (wrEn && awIdx == `PPRC_IDX_TIM)
        timReg <= wByte[4:0];
      if (wrEn && awIdx == `PPRC_IDX_STD)
        stdReg <= wByte & `PPRC_MSK_STD;
      if (wrEn && awIdx == `PPRC_IDX_LEG)
        legReg <= wByte[6:0];
      if (wrEn && awIdx == `PPRC_IDX_IMK)
        intMask <= wByte[3:0];
      // a new event wins over a write-one clear in the same cycle
      if (wrEn && awIdx == `PPRC_IDX_IST)
        intStatus <= (intStatus & ~wByte[3:0]) | intEvent;
      else
        intStatus <= intStatus | intEvent;
      irq <= |((intStatus | intEvent) & intMask);
    end
  end
  // ----------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------
  wire [7:0] rdIdx = {2'b00, s_axi_araddr[7:2]};
  reg [7:0] rdByte;
  reg rdHit;
  always @*
  begin
    rdHit = 1'b1;
    case (rdIdx)
      `PPRC_IDX_ART: rdByte = {1'b0, artReg};
      `PPRC_IDX_THR: rdByte = {4'h0, thrReg};
      `PPRC_IDX_TIM: rdByte = {3'b000, timReg};
      `PPRC_IDX_STD: rdByte = stdReg;
      `PPRC_IDX_LEG: rdByte = {1'b0, legReg};
      `PPRC_IDX_IST: rdByte = {4'h0, intStatus};
      `PPRC_IDX_IMK: rdByte = {4'h0, intMask};
      `PPRC_IDX_STA: rdByte = {errorActive, useTestCurrent, portSwitchOn,
        cooldownHold, attachEvalEnable, emulationSuccess,
        dcpProfileEnable, capRun};
      default:
      begin
        rdByte = 8'h00;
        rdHit = 1'b0;
      end
    endcase
  end
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `PPRC_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h000000, rdByte};
        s_axi_rresp <= rdHit ? `PPRC_RESP_OKAY : `PPRC_RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: hdl/pprc_defs.vh
// constants for the port power recovery and emulation configuration block
`ifndef PPRC_DEFS_VH
`define PPRC_DEFS_VH
// ----------------------------------------------------------------
// register indices, byte address is four times the index
// ----------------------------------------------------------------
`define PPRC_IDX_ART 8'h1c
`define PPRC_IDX_THR 8'h1e
`define PPRC_IDX_TIM 8'h1f
`define PPRC_IDX_STD 8'h20
`define PPRC_IDX_LEG 8'h21
`define PPRC_IDX_IST 8'h28
`define PPRC_IDX_IMK 8'h29
`define PPRC_IDX_STA 8'h2a
// ----------------------------------------------------------------
// reset values and implemented bit masks
// ----------------------------------------------------------------
`define PPRC_RST_ART 7'h2a
`define PPRC_RST_THR 4'hf
`define PPRC_RST_TIM 5'h03
`define PPRC_RST_STD 8'h16
`define PPRC_RST_LEG 7'h00
`define PPRC_MSK_STD 8'h17
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PPRC_CYC_HI 6
`define PPRC_CYC_LO 4
`define PPRC_TST_HI 3
`define PPRC_TST_LO 2
`define PPRC_VTS_HI 1
`define PPRC_VTS_LO 0
`define PPRC_COOL_HI 4
`define PPRC_COOL_LO 3
`define PPRC_CAP_HI 2
`define PPRC_CAP_LO 0
`define PPRC_DCP_BIT 4
// ----------------------------------------------------------------
// timing in milliseconds and millivolts
// ----------------------------------------------------------------
`define PPRC_CLK_KHZ 25000
`define PPRC_CYC_BASE_MS 11'd15
`define PPRC_TST_BASE_MS 11'd10
`define PPRC_STEP5_MS 11'd5
`define PPRC_VTS_STEP_MV 11'd250
`define PPRC_COOL_BASE_MS 11'd200
`define PPRC_CAP_STEP_MS 11'd200
`define PPRC_CAP_MAX_MS 11'd2000
`define PPRC_CAP_LONG_CODE 3'd7
`define PPRC_CAP_800_CODE 3'd3
// ----------------------------------------------------------------
// mode pins {emulation enable, select a, select b} for dedicated mode
// ----------------------------------------------------------------
`define PPRC_DCP_MODE 3'b111
`define PPRC_RESP_OKAY 2'b00
`define PPRC_RESP_SLVERR 2'b10
`endif

// File: hdl/pprc_ms_timer.v
// millisecond down-counting timer with start and one-cycle done pulse
`timescale 1ns/1ps
`default_nettype none
module pprc_ms_timer #(
  parameter W = 11
) (
  input wire mclk,
  input wire rst_n,
  input wire msTick,
  input wire start,
  input wire [W-1:0] loadMs,
  output reg running,
  output reg done
);
  reg [W-1:0] remain;
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      remain <= {W{1'b0}};
      running <= 1'b0;
      done <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (start)
      begin
        remain <= loadMs;
        running <= 1'b1;
      end
      else if (running && msTick)
      begin
        if (remain <= {{(W-1){1'b0}}, 1'b1})
        begin
          running <= 1'b0;
          done <= 1'b1;
        end
        remain <= remain - {{(W-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule
`default_nettype wire

// File: tb/pprc_device_model.sv
// portable device model at the usb port
`timescale 1ns/1ps
`default_nettype none
module pprc_device_model (
  input wire logic mclk,
  input wire logic portSwitchOn,
  input wire logic attached,
  input wire logic [10:0] sagMv,
  input wire logic [7:0] loadSteps,
  output logic devicePresentIn,
  output logic [10:0] vbusMilliVolt,
  output logic [7:0] busCurrentSteps
);
  initial
  begin
    devicePresentIn = 1'b0;
    vbusMilliVolt = 11'h000;
    busCurrentSteps = 8'h00;
  end
  // bus sits at the sag level while powered, no current when unpowered
  always @(posedge mclk)
  begin
    devicePresentIn <= attached;
    vbusMilliVolt <= portSwitchOn ? sagMv : 11'h000;
    busCurrentSteps <= (portSwitchOn && attached) ? loadSteps : 8'h00;
  end
endmodule
`default_nettype wire

// File: tb/pprc_checker.sv
// assertions on the recovery and emulation block ports
`timescale 1ns/1ps
`default_nettype none
module pprc_checker #(
  parameter CLK_PER_MS = 25
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [7:0] busCurrentSteps,
  input wire logic mode_select_a,
  input wire logic mode_select_b,
  input wire logic emulation_enable_input,
  input wire logic useTestCurrent,
  input wire logic portSwitchOn,
  input wire logic errorActive,
  input wire logic cooldownHold,
  input wire logic attachEvalEnable,
  input wire logic removalDetect,
  input wire logic attachDetect,
  input wire logic emulationSuccess,
  input wire logic dcpProfileEnable
);
  localparam int MS = CLK_PER_MS;
  int waitCnt;
  int coolCnt;
  int capCnt;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  // ---------------------------------------
  // cycle counters for the timed states
  // ---------------------------------------
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      waitCnt <= 0;
      coolCnt <= 0;
      capCnt <= 0;
    end
    else
    begin
      waitCnt <= (errorActive && !portSwitchOn) ? waitCnt + 1 : 0;
      coolCnt <= cooldownHold ? coolCnt + 1 : 0;
      capCnt <= attachEvalEnable ? 0 : capCnt + 1;
    end
  end
  // ---------------------------------------
  // properties
  // ---------------------------------------
  property p_test_on;
    $rose(useTestCurrent) |-> portSwitchOn;
  endproperty
  a_test_on: assert property (p_test_on) else $error("switch off in test");
  property p_short;
    $fell(portSwitchOn) |-> errorActive;
  endproperty
  a_short: assert property (p_short) else $error("short left error");
  property p_delay;
    $rose(useTestCurrent) |-> waitCnt >= 14*MS && waitCnt <= 51*MS;
  endproperty
  a_delay: assert property (p_delay) else $error("bad cycle delay");
  property p_succ_hi;
    $past(rst_n) && $past(busCurrentSteps) == 8'hff |-> emulationSuccess;
  endproperty
  a_succ_hi: assert property (p_succ_hi) else $error("no success");
  property p_succ_lo;
    $past(busCurrentSteps) == 8'h00 |-> !emulationSuccess;
  endproperty
  a_succ_lo: assert property (p_succ_lo) else $error("false success");
  property p_cool;
    $fell(cooldownHold) |-> coolCnt >= 199*MS && coolCnt <= 1601*MS;
  endproperty
  a_cool: assert property (p_cool) else $error("bad cooldown time");
  property p_cap;
    $rose(attachEvalEnable) && capCnt > 4 |->
      capCnt >= 199*MS && capCnt <= 2001*MS;
  endproperty
  a_cap: assert property (p_cap) else $error("bad charge time");
  property p_attach;
    attachDetect |-> attachEvalEnable;
  endproperty
  a_attach: assert property (p_attach) else $error("early attach");
  property p_reattach;
    removalDetect |=> attachDetect;
  endproperty
  a_reattach: assert property (p_reattach) else $error("no attach");
  property p_dcp;
    (emulation_enable_input && mode_select_a && mode_select_b) [*4]
      |=> dcpProfileEnable;
  endproperty
  a_dcp: assert property (p_dcp) else $error("profile off");
  cover property ($rose(useTestCurrent));
  cover property ($fell(cooldownHold));
  cover property (removalDetect);
endmodule
bind pprc_top pprc_checker #(.CLK_PER_MS(CLK_PER_MS)) u_pprc_checker (.*);
`default_nettype wire

// File: tb/tb_port_power_recovery_emulation_cfg.sv
// self-checking bench for the recovery and emulation register block
`timescale 1ns/1ps
`default_nettype none
`include "pprc_defs.vh"
module tb_port_power_recovery_emulation_cfg;
  logic mclk = 1'b0, rst_n = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic errorIn = 1'b0, overTempIn = 1'b0, backDriveIn = 1'b0;
  logic tempHighIn = 1'b0, busDischargedIn = 1'b0, sleepIn = 1'b0;
  logic power_switch_enable_input = 1'b0, emulation_enable_input = 1'b0;
  logic mode_select_a = 1'b0, mode_select_b = 1'b0, attached = 1'b0;
  logic [10:0] sagMv = 11'h76c;
  logic [7:0] loadSteps = 8'h00;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire s_axi_rvalid, devicePresentIn, useTestCurrent, portSwitchOn;
  wire errorActive, cooldownHold, attachEvalEnable, removalDetect;
  wire attachDetect, emulationSuccess, dcpProfileEnable, irq;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [10:0] vbusMilliVolt;
  wire [7:0] busCurrentSteps;
  wire [6:0] legacyProfileEnable;
  wire [6:0] obs = {attachDetect, removalDetect, attachEvalEnable,
    cooldownHold, errorActive, portSwitchOn, useTestCurrent};
  logic [31:0] rd;
  logic [1:0] resp;
  int bad_count = 0;
  int cmp_count = 0;
  int n, m;
  pprc_top #(.CLK_PER_MS(10)) u_pprc_top (.*);
  pprc_device_model u_pprc_device_model (.mclk(mclk),
    .portSwitchOn(portSwitchOn), .attached(attached), .sagMv(sagMv),
    .loadSteps(loadSteps), .devicePresentIn(devicePresentIn),
    .vbusMilliVolt(vbusMilliVolt), .busCurrentSteps(busCurrentSteps));
  initial
  begin
    forever #20 mclk = ~mclk;
  end
  // ---------------------------------------
  // shared tasks
  // ---------------------------------------
  task automatic conclude;
    if (bad_count == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h not %h", $time, got, exp);
    end
  endtask
  task automatic rng(input int v, input int lo, input int hi);
    chk(32'(v >= lo && v <= hi), 32'h1);
  endtask
  task automatic waitBit(input int b, input logic v, output int k);
    k = 0;
    do
    begin
      @(posedge mclk);
      k++;
    end
    while (obs[b] !== v && k < 30000);
    if (k >= 30000) tmo;
  endtask
  task automatic tmo;
    bad_count++;
    $display("wrong value at %0t: wait ran out", $time);
    conclude;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d,
    input logic [3:0] s);
    int k;
    @(posedge mclk);
    s_axi_awaddr <= {idx[5:0], 2'b00};
    s_axi_wdata <= {24'h000000, d};
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    k = 0;
    do
    begin
      @(posedge mclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      k++;
    end
    while (s_axi_bvalid !== 1'b1 && k < 100);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (k >= 100) tmo;
    // let outputs that follow the written register settle
    @(posedge mclk);
  endtask
  task automatic rdReg(input logic [7:0] idx);
    int k;
    @(posedge mclk);
    s_axi_araddr <= {idx[5:0], 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    k = 0;
    do
    begin
      @(posedge mclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      k++;
    end
    while (s_axi_rvalid !== 1'b1 && k < 100);
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (k >= 100) tmo;
  endtask
  // ---------------------------------------
  // scenarios
  // ---------------------------------------
  task automatic t_regs;
    logic [7:0] ix [5] = '{`PPRC_IDX_ART, `PPRC_IDX_THR, `PPRC_IDX_TIM,
      `PPRC_IDX_STD, `PPRC_IDX_LEG};
    logic [7:0] rv [5] = '{8'h2a, 8'h0f, 8'h03, 8'h16, 8'h00};
    logic [7:0] wm [5] = '{8'h7f, 8'h0f, 8'h1f, 8'h17, 8'h7f};
    for (int i = 0; i < 5; i++)
    begin
      rdReg(ix[i]);
      chk(rd, {24'h0, rv[i]});
      wr(ix[i], 8'hff, 4'hf);
      rdReg(ix[i]);
      chk(rd, {24'h0, wm[i]});
      wr(ix[i], rv[i], 4'hf);
    end
    chk(dcpProfileEnable, 32'h0);
    wr(`PPRC_IDX_STD, 8'h06, 4'hf);
    chk(dcpProfileEnable, 32'h1);
    wr(`PPRC_IDX_STD, 8'h16, 4'hf);
    wr(`PPRC_IDX_LEG, 8'h41, 4'hf);
    chk(legacyProfileEnable, 32'h3e);
    wr(8'h10, 8'h01, 4'hf);
    chk(resp, `PPRC_RESP_SLVERR);
    rdReg(8'h10);
    chk(rd, 32'h0);
    chk(resp, `PPRC_RESP_SLVERR);
    wr(`PPRC_IDX_THR, 8'h05, 4'h0);
    rdReg(`PPRC_IDX_THR);
    chk(rd, 32'h0f);
  endtask
  task automatic t_pins;
    {emulation_enable_input, mode_select_a, mode_select_b} <= 3'h7;
    repeat (5) @(posedge mclk);
    chk(dcpProfileEnable, 32'h1);
    {emulation_enable_input, mode_select_a, mode_select_b} <= 3'h0;
    wr(`PPRC_IDX_THR, 8'h03, 4'hf);
    wr(`PPRC_IDX_ART, 8'h45, 4'hf);
    wr(`PPRC_IDX_TIM, 8'h04, 4'hf);
    sleepIn <= 1'b1;
    repeat (6) @(posedge mclk);
    sleepIn <= 1'b0;
    repeat (4) @(posedge mclk);
    rdReg(`PPRC_IDX_THR);
    chk(rd, 32'h0f);
    rdReg(`PPRC_IDX_ART);
    chk(rd, 32'h45);
    rdReg(`PPRC_IDX_TIM);
    chk(rd, 32'h04);
  endtask
  task automatic t_recov;
    sagMv <= 11'h1f0;
    errorIn <= 1'b1;
    waitBit(0, 1'b1, n);
    rng(n, 340, 365);
    chk(portSwitchOn, 32'h1);
    errorIn <= 1'b0;
    sagMv <= 11'h1f0;
    waitBit(1, 1'b0, n);
    rng(n, 140, 155);
    chk(errorActive, 32'h1);
    sagMv <= 11'h1f8;
    waitBit(1, 1'b1, n);
    rng(n, 340, 365);
    waitBit(2, 1'b0, n);
    rng(n, 140, 155);
    chk({errorActive, portSwitchOn}, 32'h1);
    rdReg(`PPRC_IDX_IST);
    chk(rd, 32'h01);
    chk(irq, 32'h0);
    wr(`PPRC_IDX_IMK, 8'h01, 4'hf);
    chk(irq, 32'h1);
    wr(`PPRC_IDX_IST, 8'h01, 4'hf);
    chk(irq, 32'h0);
  endtask
  task automatic t_load;
    wr(`PPRC_IDX_THR, 8'h03, 4'hf);
    attached <= 1'b1;
    loadSteps <= 8'h03;
    repeat (4) @(posedge mclk);
    chk(emulationSuccess, 32'h0);
    loadSteps <= 8'h04;
    repeat (4) @(posedge mclk);
    chk(emulationSuccess, 32'h1);
    loadSteps <= 8'hff;
    repeat (4) @(posedge mclk);
    chk(emulationSuccess, 32'h1);
    loadSteps <= 8'h00;
  endtask
  task automatic t_cap;
    busDischargedIn <= 1'b1;
    tempHighIn <= 1'b1;
    waitBit(3, 1'b1, n);
    waitBit(3, 1'b0, m);
    rng(m, 1990, 2010);
    n += m;
    chk(attachEvalEnable, 32'h0);
    busDischargedIn <= 1'b0;
    tempHighIn <= 1'b0;
    waitBit(5, 1'b1, m);
    rng(n + m, 9985, 10020);
    @(posedge mclk);
    chk(attachDetect, 32'h1);
  endtask
  initial
  begin
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    t_regs;
    t_pins;
    t_recov;
    t_load;
    t_cap;
    conclude;
  end
endmodule
`default_nettype wire
